// ---- logic/sync_serial_pkg.sv ----
// Constants and types shared by the multimode serial channel
package sync_serial_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [15:0] IDX_PRESCALE = 16'hFF43;
  localparam logic [15:0] IDX_MODE     = 16'hFF60;
  localparam logic [15:0] IDX_BUSCTL   = 16'hFF61;
  localparam logic [15:0] IDX_TIMING   = 16'hFF62;
  localparam logic [15:0] IDX_SHIFT    = 16'hFF63;
  localparam logic [15:0] IDX_SLAVE    = 16'hFF64;
  // Reset values
  localparam logic [7:0] PRESCALE_RESET = 8'h88;
  localparam logic [7:0] MODE_RESET     = 8'h00;
  // Mode register fields
  localparam int MODE_ENABLE  = 7;
  localparam int MODE_MATCH   = 6;
  localparam int MODE_WAKEUP  = 5;
  localparam int MODE_SEL_HI  = 4;
  localparam int MODE_SEL_LO  = 3;
  localparam int MODE_FIRST   = 2;
  localparam int MODE_SRC_HI  = 1;
  localparam int MODE_SRC_LO  = 0;
  // Bus control register fields
  localparam int BUS_BUSY_EN  = 7;
  localparam int BUS_CMD_DET  = 3;
  localparam int BUS_REL_DET  = 2;
  localparam int BUS_CMD_OUT  = 1;
  localparam int BUS_REL_OUT  = 0;
  // Interrupt timing register fields
  localparam int TIM_CLK_LVL  = 6;
  localparam int TIM_REL_IRQ  = 5;
  localparam int TIM_ADR_MASK = 4;
  // Clock source codes
  localparam logic [1:0] SRC_TIMER    = 2'b10;
  localparam logic [1:0] SRC_PRESCALE = 2'b11;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    OP_THREE_WIRE   = 2'b00,
    OP_THREE_WIRE_X = 2'b01,
    OP_ADDR_BUS     = 2'b10,
    OP_PLAIN_2W     = 2'b11
  } op_mode_t;

  typedef enum logic [0:0] {
    ENG_IDLE = 1'b0,
    ENG_RUN  = 1'b1
  } eng_state_t;
endpackage

// ---- logic/sync_serial_channel.sv ----
// Multimode synchronous serial channel with AXI4-Lite register access
// Notes on behaviour
// [RL1] 8-bit shift register moves bits with clock
// [RL2] Shift write while enabled starts one transfer
// [RL3] Bus receivers preload all ones first
// [RL4] Shift write ends busy, busy enable kept
// [RL5] Shift and slave address have no reset
// [RL6] Address match sets read-only match flag
// [RL7] Mask bit drops address LSB from compare
// [RL8] Address mismatch clears release detected flag
// [RL9] Wake-up: interrupt only on address match
// [RL10] Release select: disable wake-up, interrupt on release
// [RL11] Output latch settable; set after 8th clock in addressed bus mode
// [RL12] Clock counter finds end of eight bits
// [RL13] Gate clock; drive pin when internally sourced
// [RL14] Interrupt every eight clocks outside wake-up
// [RL15] Bus detectors and busy only in addressed mode
// [RL16] Prescale codes 0110..1101 give fxx/2..fxx/2^8
// [RL17] Prescale register resets to 88H
// [RL18] Software stops transfer before prescale change
// [RL19] Clock source: external, timer, or prescaler
// [RL20] Mode bits pick wire mode, order, bus line
// [RL21] Unused data pin stays free as port
// [RL22] Software stops channel before mode change
// [RL23] Match flag ignores software writes
// [RL24] Match flag held zero while disabled
// [RL25] Release output bit sets latch, self-clears
// [RL26] Change data on falling, sample on rising
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module sync_serial_channel (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial pins
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe_n,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  input  wire logic        bus_data_line_a_in,
  output logic             bus_data_line_a_out,
  output logic             bus_data_line_a_oe_n,
  input  wire logic        bus_data_line_b_in,
  output logic             bus_data_line_b_out,
  output logic             bus_data_line_b_oe_n,
  // System side
  input  wire logic        eight_bit_timer_output,
  input  wire logic        oscillator_divide_select,
  output logic             transfer_end_interrupt
);

  function automatic logic reg_hit(input logic [31:0] addr, input logic [15:0] idx);
    reg_hit = (addr[31:18] == 14'h0000) && (addr[17:2] == idx);
  endfunction

  // Half period of the internal serial clock in core cycles
  function automatic logic [7:0] half_period(input logic [3:0] code, input logic osc);
    case (code)
      4'h6:    half_period = osc ? 8'h02 : 8'h01;
      4'h7:    half_period = 8'h02;
      4'h8:    half_period = 8'h04;
      4'h9:    half_period = 8'h08;
      4'hA:    half_period = 8'h10;
      4'hB:    half_period = 8'h20;
      4'hC:    half_period = 8'h40;
      4'hD:    half_period = 8'h80;
      default: half_period = 8'h80;
    endcase
  endfunction

  // Bus slave state
  logic        aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
  logic        w_strb0, next_w_strb0;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        wr_go;

  // Control state
  logic [7:0]  prescale, next_prescale;
  logic [7:0]  mode_ctl, next_mode_ctl;
  logic        match_flag, next_match_flag;
  logic        busy_en, next_busy_en, rel_det, next_rel_det, cmd_det, next_cmd_det;
  logic        addr_mask, next_addr_mask, rel_irq_sel, next_rel_irq_sel;
  logic        out_latch, next_out_latch, busy, next_busy;
  logic        sck_q, next_sck_q;
  logic [7:0]  div_cnt, next_div_cnt;
  logic [2:0]  bit_cnt, next_bit_cnt;
  sync_serial_pkg::eng_state_t state, next_state;
  logic        clk_prev, timer_prev, line_prev, own_prev;
  logic        next_irq, next_sck_oe_n, next_so, next_own;
  logic        next_a_oe_n, next_b_oe_n;

  // Data registers without reset
  logic [7:0]  shift_data, next_shift_data, slave_addr, next_slave_addr;

  // Decoded controls
  logic        en, is_sbi, is_2w, is_plain, line_a_sel, lsb_first, drive_clk, timer_src;
  logic        line_in, data_in, sck_level, tick, fall_ev, rise_ev, done;
  logic        rel_ev, cmd_ev, start, addr_phase, match, wake_filter;
  logic [7:0]  half, rx_word, cmp_mask;
  logic        wr_mode, wr_bus, wr_tim, wr_pre, wr_shift, wr_slave;

  assign en         = mode_ctl[sync_serial_pkg::MODE_ENABLE];
  assign is_sbi     = mode_ctl[4:3] == sync_serial_pkg::OP_ADDR_BUS;               // RL20
  assign is_plain   = mode_ctl[4:3] == sync_serial_pkg::OP_PLAIN_2W;
  assign is_2w      = mode_ctl[sync_serial_pkg::MODE_SEL_HI];
  assign line_a_sel = mode_ctl[sync_serial_pkg::MODE_FIRST];                       // RL20
  assign lsb_first  = !is_2w && mode_ctl[sync_serial_pkg::MODE_FIRST];             // RL20
  assign drive_clk  = mode_ctl[sync_serial_pkg::MODE_SRC_HI];                      // RL19
  assign timer_src  = mode_ctl[1:0] == sync_serial_pkg::SRC_TIMER;                 // RL19
  assign half       = half_period(prescale[3:0], oscillator_divide_select);        // RL16
  assign line_in    = line_a_sel ? bus_data_line_a_in : bus_data_line_b_in;
  assign data_in    = is_2w ? line_in : serial_in_pin;
  assign sck_level  = drive_clk ? sck_q : serial_clock_pin_in;

  // Serial clock gating and edge events
  assign tick = drive_clk && (timer_src ? (eight_bit_timer_output && !timer_prev)
                                        : (div_cnt == half - 8'h01));              // RL13
  assign fall_ev = (state == sync_serial_pkg::ENG_RUN) &&
                   (drive_clk ? (tick && sck_q) : (clk_prev && !serial_clock_pin_in));
  assign rise_ev = (state == sync_serial_pkg::ENG_RUN) &&
                   (drive_clk ? (tick && !sck_q) : (!clk_prev && serial_clock_pin_in));
  assign done    = rise_ev && (bit_cnt == sync_serial_pkg::LAST_BIT);              // RL12

  // Release and command seen while clock is high; own release masked
  assign rel_ev = en && is_sbi && own_prev && sck_level && line_in && !line_prev;  // RL15
  assign cmd_ev = en && is_sbi && sck_level && !line_in && line_prev;              // RL15

  // Address comparison
  assign rx_word    = lsb_first ? {data_in, shift_data[7:1]} : {shift_data[6:0], data_in};
  assign cmp_mask   = {7'h7F, !addr_mask};                                         // RL7
  assign match      = ((rx_word ^ slave_addr) & cmp_mask) == 8'h00;                // RL6
  assign addr_phase = is_sbi && rel_det && cmd_det;
  assign wake_filter = is_sbi && mode_ctl[sync_serial_pkg::MODE_WAKEUP] && !rel_irq_sel;

  // Register write decode
  assign wr_go    = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_mode  = wr_go && w_strb0 && reg_hit(aw_addr, sync_serial_pkg::IDX_MODE);
  assign wr_bus   = wr_go && w_strb0 && reg_hit(aw_addr, sync_serial_pkg::IDX_BUSCTL);
  assign wr_tim   = wr_go && w_strb0 && reg_hit(aw_addr, sync_serial_pkg::IDX_TIMING);
  assign wr_pre   = wr_go && w_strb0 && reg_hit(aw_addr, sync_serial_pkg::IDX_PRESCALE);
  assign wr_shift = wr_go && w_strb0 && reg_hit(aw_addr, sync_serial_pkg::IDX_SHIFT);
  assign wr_slave = wr_go && w_strb0 && reg_hit(aw_addr, sync_serial_pkg::IDX_SLAVE);
  assign start    = wr_shift && en;                                                // RL2

  // Bus slave next state
  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_strb0 = w_strb0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold  = 1'b1;
      next_w_data  = s_axi_wdata;
      next_w_strb0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_mode || wr_bus || wr_tim || wr_pre || wr_shift || wr_slave ||
                      (!w_strb0 && aw_addr[31:18] == 14'h0000 &&
                       (aw_addr[17:2] >= sync_serial_pkg::IDX_MODE &&
                        aw_addr[17:2] <= sync_serial_pkg::IDX_SLAVE ||
                        aw_addr[17:2] == sync_serial_pkg::IDX_PRESCALE)))
                     ? sync_serial_pkg::RESP_OKAY : sync_serial_pkg::RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = sync_serial_pkg::RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (reg_hit(s_axi_araddr, sync_serial_pkg::IDX_PRESCALE)) begin
        next_rdata[7:0] = prescale;
      end else if (reg_hit(s_axi_araddr, sync_serial_pkg::IDX_MODE)) begin
        next_rdata[7:0] = {mode_ctl[7], match_flag, mode_ctl[5:0]};
      end else if (reg_hit(s_axi_araddr, sync_serial_pkg::IDX_BUSCTL)) begin
        next_rdata[7:0] = {busy_en, 3'h0, cmd_det, rel_det, 2'h0};
      end else if (reg_hit(s_axi_araddr, sync_serial_pkg::IDX_TIMING)) begin
        next_rdata[7:0] = {1'b0, en && sck_level, rel_irq_sel, addr_mask, 4'h0};
      end else if (reg_hit(s_axi_araddr, sync_serial_pkg::IDX_SHIFT)) begin
        next_rdata[7:0] = shift_data;
      end else if (reg_hit(s_axi_araddr, sync_serial_pkg::IDX_SLAVE)) begin
        next_rdata[7:0] = slave_addr;
      end else begin
        next_rresp = sync_serial_pkg::RESP_SLVERR;
      end
    end
    next_awready = !next_aw_hold;
    next_wready  = !next_w_hold;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold       <= 1'b0;
      aw_addr       <= 32'h0000_0000;
      w_hold        <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb0       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      aw_hold       <= next_aw_hold;
      aw_addr       <= next_aw_addr;
      w_hold        <= next_w_hold;
      w_data        <= next_w_data;
      w_strb0       <= next_w_strb0;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
  end

  // Control, transfer engine and pins
  always_comb begin
    next_prescale    = wr_pre ? w_data[7:0] : prescale;                            // RL18
    next_mode_ctl    = wr_mode ? w_data[7:0] : mode_ctl;                           // RL22
    next_mode_ctl[sync_serial_pkg::MODE_MATCH] = 1'b0;                             // RL23
    next_busy_en     = wr_bus ? w_data[sync_serial_pkg::BUS_BUSY_EN] : busy_en;    // RL4
    next_addr_mask   = wr_tim ? w_data[sync_serial_pkg::TIM_ADR_MASK] : addr_mask;
    next_rel_irq_sel = wr_tim ? w_data[sync_serial_pkg::TIM_REL_IRQ] : rel_irq_sel;
    next_state       = state;
    next_bit_cnt     = bit_cnt;
    next_sck_q       = sck_q;
    next_out_latch   = out_latch;
    next_match_flag  = match_flag;
    next_rel_det     = rel_det;
    next_cmd_det     = cmd_det;
    next_busy        = busy;
    next_irq         = 1'b0;
    next_div_cnt     = 8'h00;
    if (state == sync_serial_pkg::ENG_RUN && drive_clk && !timer_src && !tick) begin
      next_div_cnt = div_cnt + 8'h01;
    end
    // Engine sequencing
    if (start) begin
      next_state   = sync_serial_pkg::ENG_RUN;                                     // RL2
      next_bit_cnt = 3'h0;
    end else if (done) begin
      next_state = sync_serial_pkg::ENG_IDLE;
    end else if (rise_ev) begin
      next_bit_cnt = bit_cnt + 3'h1;                                               // RL12
    end
    if (tick && state == sync_serial_pkg::ENG_RUN) begin
      next_sck_q = !sck_q;                                                         // RL13
    end
    if (fall_ev) begin
      next_out_latch = lsb_first ? shift_data[0] : shift_data[7];                  // RL26
    end
    if (done && is_sbi) begin
      next_out_latch = 1'b1;                                                       // RL11
    end
    if (wr_bus && w_data[sync_serial_pkg::BUS_CMD_OUT]) begin
      next_out_latch = 1'b0;
    end
    if (wr_bus && w_data[sync_serial_pkg::BUS_REL_OUT]) begin
      next_out_latch = 1'b1;                                                       // RL25
    end
    // Address comparison result
    if (done && addr_phase) begin
      next_match_flag = match;                                                     // RL6
    end
    // Release and command detectors, set beats clear
    if (done && addr_phase && !match) begin
      next_rel_det = 1'b0;                                                         // RL8
    end
    if (rel_ev) begin
      next_rel_det = 1'b1;
      next_cmd_det = 1'b0;
    end
    if (cmd_ev) begin
      next_cmd_det = 1'b1;
    end
    // Busy handshake
    if (done && busy_en && is_sbi) begin
      next_busy = 1'b1;
    end
    if (wr_shift) begin
      next_busy = 1'b0;                                                            // RL4
    end
    // Interrupt generation
    if (done && (!wake_filter || (addr_phase && match))) begin
      next_irq = 1'b1;                                                             // RL14 RL9
    end
    if (rel_ev && rel_irq_sel) begin
      next_irq = 1'b1;                                                             // RL10
    end
    if (!next_mode_ctl[sync_serial_pkg::MODE_ENABLE]) begin
      next_state      = sync_serial_pkg::ENG_IDLE;
      next_match_flag = 1'b0;                                                      // RL24
      next_rel_det    = 1'b0;
      next_cmd_det    = 1'b0;
      next_busy       = 1'b0;
    end
    if (next_mode_ctl[4:3] != sync_serial_pkg::OP_ADDR_BUS) begin
      next_rel_det = 1'b0;                                                         // RL15
      next_cmd_det = 1'b0;
      next_busy    = 1'b0;
    end
    if (!next_mode_ctl[sync_serial_pkg::MODE_SRC_HI] ||
        next_state == sync_serial_pkg::ENG_IDLE) begin
      next_sck_q = 1'b1;
    end
    // Pin drive
    next_own      = next_out_latch && !next_busy;                                  // RL3
    next_so       = next_out_latch;
    next_sck_oe_n = !(next_mode_ctl[sync_serial_pkg::MODE_ENABLE] &&
                      next_mode_ctl[sync_serial_pkg::MODE_SRC_HI]) ||
                    (next_mode_ctl[4:3] == sync_serial_pkg::OP_PLAIN_2W && next_sck_q);
    next_a_oe_n   = 1'b1;                                                          // RL21
    next_b_oe_n   = 1'b1;
    if (next_mode_ctl[sync_serial_pkg::MODE_ENABLE] &&
        next_mode_ctl[sync_serial_pkg::MODE_SEL_HI]) begin
      if (next_mode_ctl[sync_serial_pkg::MODE_FIRST]) begin
        next_a_oe_n = next_own;                                                    // RL20
      end else begin
        next_b_oe_n = next_own;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale              <= sync_serial_pkg::PRESCALE_RESET;                    // RL17
      mode_ctl              <= sync_serial_pkg::MODE_RESET;
      match_flag            <= 1'b0;
      busy_en               <= 1'b0;
      rel_det               <= 1'b0;
      cmd_det               <= 1'b0;
      addr_mask             <= 1'b0;
      rel_irq_sel           <= 1'b0;
      out_latch             <= 1'b1;
      busy                  <= 1'b0;
      sck_q                 <= 1'b1;
      div_cnt               <= 8'h00;
      bit_cnt               <= 3'h0;
      state                 <= sync_serial_pkg::ENG_IDLE;
      clk_prev              <= 1'b1;
      timer_prev            <= 1'b0;
      line_prev             <= 1'b1;
      own_prev              <= 1'b1;
      transfer_end_interrupt <= 1'b0;
      serial_clock_pin_out  <= 1'b1;
      serial_clock_pin_oe_n <= 1'b1;
      serial_out_pin        <= 1'b1;
      bus_data_line_a_out   <= 1'b0;
      bus_data_line_a_oe_n  <= 1'b1;
      bus_data_line_b_out   <= 1'b0;
      bus_data_line_b_oe_n  <= 1'b1;
    end else begin
      prescale              <= next_prescale;
      mode_ctl              <= next_mode_ctl;
      match_flag            <= next_match_flag;
      busy_en               <= next_busy_en;
      rel_det               <= next_rel_det;
      cmd_det               <= next_cmd_det;
      addr_mask             <= next_addr_mask;
      rel_irq_sel           <= next_rel_irq_sel;
      out_latch             <= next_out_latch;
      busy                  <= next_busy;
      sck_q                 <= next_sck_q;
      div_cnt               <= next_div_cnt;
      bit_cnt               <= next_bit_cnt;
      state                 <= next_state;
      clk_prev              <= serial_clock_pin_in;
      timer_prev            <= eight_bit_timer_output;
      line_prev             <= line_in;
      own_prev              <= line_a_sel ? bus_data_line_a_oe_n : bus_data_line_b_oe_n;
      transfer_end_interrupt <= next_irq;
      serial_clock_pin_out  <= next_sck_q;                                         // RL13
      serial_clock_pin_oe_n <= next_sck_oe_n;
      serial_out_pin        <= next_so;
      bus_data_line_a_out   <= 1'b0;
      bus_data_line_a_oe_n  <= next_a_oe_n;
      bus_data_line_b_out   <= 1'b0;
      bus_data_line_b_oe_n  <= next_b_oe_n;
    end
  end

  // Shift and slave address registers
  always_comb begin
    next_shift_data = shift_data;
    next_slave_addr = wr_slave ? w_data[7:0] : slave_addr;
    if (wr_shift) begin
      next_shift_data = w_data[7:0];
    end else if (rise_ev) begin
      next_shift_data = rx_word;                                                   // RL1 RL26
    end
  end

  always_ff @(posedge core_clk) begin
    shift_data <= next_shift_data;                                                 // RL5
    slave_addr <= next_slave_addr;
  end

endmodule // sync_serial_channel

// ---- sim/serial_peer_model.sv ----
// Three-wire peripheral model on the far side of the serial pins
`timescale 1ns/1ps
module serial_peer_model (
  // Serial pins
  input  wire logic       reset_n,
  input  wire logic       sclk,
  input  wire logic       sdo,
  output logic            sdi,
  // Data
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  logic [2:0] bit_idx;
  initial sdi = 1'h1;
  always @(negedge sclk) sdi <= tx_byte[3'h7 - bit_idx];
  always @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      bit_idx <= 3'h0;
    end else begin
      rx_byte <= {rx_byte[6:0], sdo};
      bit_idx <= bit_idx + 3'h1;
    end
  end
endmodule // serial_peer_model

// ---- sim/sync_serial_channel_properties.sv ----
// Port checks for the serial channel
`timescale 1ns/1ps
module sync_serial_channel_properties (
  // Clock, reset and bus handshakes
  input wire logic core_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Serial side
  input wire logic serial_clock_pin_out, bus_data_line_a_out, bus_data_line_b_out,
  input wire logic transfer_end_interrupt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] rises;
  logic       clk_d;
  wire        rise_now = serial_clock_pin_out && !clk_d;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rises <= 4'h0;
      clk_d <= 1'h1;
    end else begin
      clk_d <= serial_clock_pin_out;
      rises <= transfer_end_interrupt ? 4'h0 : rises + 4'(rise_now);
    end
  end
  a_irq_bits: assert property (transfer_end_interrupt |-> rises + 4'(rise_now) == 4'h8)
    else $error("interrupt not after eight clock rises");
  a_irq_pulse: assert property (transfer_end_interrupt |=> !transfer_end_interrupt)
    else $error("interrupt longer than one cycle");
  a_line_drive: assert property (!bus_data_line_a_out && !bus_data_line_b_out)
    else $error("bus line driven high");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write response");
  a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("late read data");
  a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read data held");
  a_read_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  c_irq: cover property (transfer_end_interrupt);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // sync_serial_channel_properties
bind sync_serial_channel sync_serial_channel_properties i_props (.*);

// ---- sim/testbench.sv ----
// Self-checking bench for the multimode serial channel
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'h0, reset_n = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, transfer_end_interrupt;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic serial_clock_pin_out, serial_clock_pin_oe_n, serial_in_pin, serial_out_pin;
  logic bus_data_line_a_out, bus_data_line_a_oe_n, bus_data_line_b_out, bus_data_line_b_oe_n;
  logic eight_bit_timer_output = 1'h0, oscillator_divide_select = 1'h0, bus_low = 1'h0;
  logic [7:0] peer_tx = 8'h00, peer_rx;
  int errors = 0, tests_run = 0;
  wire serial_clock_pin_in = serial_clock_pin_oe_n ? 1'h1 : serial_clock_pin_out;
  wire bus_data_line_a_in = bus_data_line_a_oe_n ? 1'h1 : bus_data_line_a_out;
  wire bus_data_line_b_in = !bus_low && (bus_data_line_b_oe_n || bus_data_line_b_out);
  always #4 core_clk = ~core_clk;
  sync_serial_channel i_dut (.*);
  serial_peer_model i_peer (.reset_n(reset_n), .sclk(serial_clock_pin_in),
    .sdo(serial_out_pin), .sdi(serial_in_pin), .tx_byte(peer_tx), .rx_byte(peer_rx));
  task automatic chk(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                    input logic [1:0] er = sync_serial_pkg::RESP_OKAY);
    s_axi_awaddr <= {14'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] exp,
                    input logic [1:0] er = sync_serial_pkg::RESP_OKAY);
    s_axi_araddr <= {14'h0, idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    chk("rdata", 32'(exp), s_axi_rdata);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction
  task automatic t_map;
    rd(sync_serial_pkg::IDX_PRESCALE, 8'h88);
    rd(sync_serial_pkg::IDX_MODE, 8'h00);
    rd(16'h0010, 8'h00, sync_serial_pkg::RESP_SLVERR);
    wr(16'h0010, 8'hFF, sync_serial_pkg::RESP_SLVERR);
    wr(sync_serial_pkg::IDX_MODE, 8'h40);
    rd(sync_serial_pkg::IDX_MODE, 8'h00);
    wr(sync_serial_pkg::IDX_PRESCALE, 8'h86);
  endtask
  task automatic t_wire(input logic lsb, input logic [7:0] tx, rx);
    wr(sync_serial_pkg::IDX_MODE, 8'h00);
    wr(sync_serial_pkg::IDX_MODE, {5'h10, lsb, 2'h3});
    peer_tx <= rx;
    wr(sync_serial_pkg::IDX_SHIFT, tx);
    @(posedge core_clk iff transfer_end_interrupt);
    rd(sync_serial_pkg::IDX_SHIFT, lsb ? rev(rx) : rx);
    chk("peer", 32'(lsb ? rev(tx) : tx), 32'(peer_rx));
  endtask
  task automatic t_addr;
    wr(sync_serial_pkg::IDX_MODE, 8'h00);
    wr(sync_serial_pkg::IDX_SLAVE, 8'h01);
    wr(sync_serial_pkg::IDX_TIMING, 8'h10);
    wr(sync_serial_pkg::IDX_MODE, 8'h93);
    bus_low <= 1'h1;
    repeat (2) @(posedge core_clk) bus_low <= !bus_low;
    @(posedge core_clk);
    wr(sync_serial_pkg::IDX_SHIFT, 8'hFF);
    @(posedge core_clk iff transfer_end_interrupt);
    rd(sync_serial_pkg::IDX_MODE, 8'hD3);
    bus_low <= 1'h0;
    wr(sync_serial_pkg::IDX_MODE, 8'h40);
    rd(sync_serial_pkg::IDX_MODE, 8'h00);
  endtask
  task automatic summarize;
    $display("errors %0d, tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'h1;
    @(posedge core_clk);
    t_map();
    t_wire(1'h0, 8'hA5, 8'h3C);
    t_wire(1'h1, 8'h81, 8'h4E);
    t_addr();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    summarize();
  end
endmodule // testbench
